// ---- dv/tb_top.sv ----
// self-checking bench for the two-channel break matcher
`timescale 1ns/100ps
`include "ubm_defs.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_top;
    import ubm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, req_from_cpu;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, break_ack, break_req, irq, se;
    logic [3:0] interrupt_mask_level;
    ubm_cycle_t bus_cycle;
    ubm_exec_t exec_info;
    ubm_cfg_t c;
    int err_total = 0;
    int checked = 0;
    // fetch conditions that can never hit
    logic [31:0] fa [3] = '{32'h200, 32'h201, 32'h200};
    logic [7:0] fs [3] = '{8'h25, 8'h15, 8'h16};
    ////////////////////////////////////////////////////////////
    ubm_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .req_from_cpu, .prdata, .pready, .pslverr, .bus_cycle,
        .exec_info, .interrupt_mask_level, .break_ack, .break_req, .irq);
    ubm_core_model core_u (.pclk, .bus_cycle, .exec_info, .break_ack);
    // 40 mhz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // watchdog, far beyond the roughly 700 cycles of the tests
    initial begin
        #100us;
        err_total++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////
    // one apb transfer; pready and data read pre-edge at the edge
    task apb(input logic w, input logic cpu, input logic [7:0] a,
             input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        req_from_cpu <= cpu;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, 1'b1, a, d, rd, se);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, 1'b1, a, 32'h0, rd, se);
        `CHK("prdata", e, rd)
    endtask
    // full setup, then a dummy read so the settings surely apply
    task cfg(input ubm_cfg_t k);
        wr(`UBM_OFS_A_ADDR, k.a_addr);
        wr(`UBM_OFS_A_MASK, k.a_mask);
        wr(`UBM_OFS_A_SEL, {24'h0, k.a_sel});
        wr(`UBM_OFS_B_ADDR, k.b_addr);
        wr(`UBM_OFS_B_MASK, k.b_mask);
        wr(`UBM_OFS_B_SEL, {24'h0, k.b_sel});
        wr(`UBM_OFS_B_DATA, k.b_data);
        wr(`UBM_OFS_B_DMASK, k.b_dmask);
        wr(`UBM_OFS_CTRL, {28'h0, k.ctl});
        apb(1'b0, 1'b1, `UBM_OFS_CTRL, 32'h0, rd, se);
    endtask
    // watch three cycles for a break; accept it if one came
    task brk(input string n, input logic e);
        logic s;
        s = 1'b0;
        repeat (3) begin
            @(posedge pclk);
            s = s | (break_req === 1'b1);
        end
        `CHK(n, e, s)
        if (s) core_u.ack();
    endtask
    task stop_test();
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        req_from_cpu = 1'b1;
        interrupt_mask_level = 4'h0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset state and an unmapped place
        rchk(`UBM_OFS_CTRL, 32'h0);
        rchk(8'h3c, 32'h0);
        `CHK("irq", 1'b0, irq)
        // a foreign master is refused and changes nothing
        apb(1'b1, 1'b0, `UBM_OFS_A_ADDR, 32'h1234_5678, rd, se);
        `CHK("pslverr", 1'b1, se)
        rchk(`UBM_OFS_A_ADDR, 32'h0);
        // channel a, cpu data read, any size, native mode
        c = '0;
        c.a_addr = 32'h0012_3456;
        c.a_sel = 8'h19;
        cfg(c);
        wr(`UBM_OFS_IRQ_MSK, 32'h4);
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 32'h0012_3454, 32'h0);
        brk("long_cover", 1'b1);
        `CHK("irq", 1'b1, irq)
        rchk(`UBM_OFS_IRQ_STS, 32'h5);
        @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        rchk(`UBM_OFS_CTRL, 32'h10);
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h1, 1'b0, 32'h0012_3456, 32'h0);
        brk("word_cover", 1'b1);
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 32'h0012_3455, 32'h0);
        brk("byte_miss", 1'b0);
        // compatible mode: full address, no flags
        c.ctl = 4'h8;
        cfg(c);
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 32'h0012_3454, 32'h0);
        brk("compat_long", 1'b0);
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 32'h0012_3456, 32'h0);
        brk("compat_byte", 1'b1);
        core_u.xcyc(32'h0012_3456);
        brk("compat_ext", 1'b0);
        rchk(`UBM_OFS_CTRL, 32'h8);
        // channel b, masked address and data, word writes
        c = '0;
        c.b_addr = 32'h000a_bcde;
        c.b_mask = 32'h0000_00ff;
        c.b_data = 32'h0000_a512;
        c.b_sel = 8'ha9;
        cfg(c);
        wr(`UBM_OFS_IRQ_MSK, 32'h0);
        core_u.cyc(1'b1, 1'b0, 1'b1, 2'h1, 1'b0, 32'h000a_bc00, 32'ha512);
        brk("b_masked", 1'b1);
        `CHK("irq", 1'b0, irq)
        core_u.cyc(1'b1, 1'b0, 1'b1, 2'h1, 1'b0, 32'h000a_bc00, 32'ha513);
        brk("b_data_miss", 1'b0);
        c.b_dmask = 32'h0000_000f;
        cfg(c);
        core_u.cyc(1'b1, 1'b0, 1'b1, 2'h1, 1'b0, 32'h000a_bcfe, 32'ha513);
        brk("b_data_mask", 1'b1);
        // sequential: same-cycle hits do not count
        c = '0;
        c.a_addr = 32'h100;
        c.b_addr = 32'h100;
        c.a_sel = 8'h19;
        c.b_sel = 8'h19;
        c.ctl = 4'h1;
        cfg(c);
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 32'h100, 32'h0);
        brk("seq_same", 1'b0);
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 32'h100, 32'h0);
        brk("seq_later", 1'b1);
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 32'h100, 32'h0);
        brk("seq_reset", 1'b0);
        // impossible fetch conditions
        for (int i = 0; i < 3; i++) begin
            c = '0;
            c.a_addr = fa[i];
            c.a_sel = fs[i];
            // for the odd address only, mask bit 0 so only the odd-address rule can refuse
            c.a_mask = {31'h0, i == 1};
            cfg(c);
            core_u.cyc(i != 2, 1'b1, i == 0, 2'h1, 1'b0, fa[i], 32'h0);
            core_u.run(32'h200);
            brk("fetch_never", 1'b0);
        end
        // native fetch: only an executed instruction breaks
        c.a_addr = 32'h200;
        c.a_sel = 8'h15;
        cfg(c);
        core_u.cyc(1'b1, 1'b1, 1'b0, 2'h1, 1'b0, 32'h200, 32'h0);
        core_u.run(32'h204);
        brk("overrun", 1'b0);
        core_u.cyc(1'b1, 1'b1, 1'b0, 2'h1, 1'b0, 32'h200, 32'h0);
        core_u.run(32'h200);
        brk("fetch_exec", 1'b1);
        // after-execution timing on channel a, then a compatible-mode fetch
        c.ctl = 4'h2;
        cfg(c);
        core_u.cyc(1'b1, 1'b1, 1'b0, 2'h1, 1'b0, 32'h200, 32'h0);
        core_u.run(32'h200);
        brk("fetch_after", 1'b1);
        c.ctl = 4'h8;
        cfg(c);
        core_u.cyc(1'b1, 1'b1, 1'b0, 2'h1, 1'b0, 32'h200, 32'h0);
        brk("compat_fetch", 1'b1);
        // sequence of fetch a (before execution) then data b
        c.a_addr = 32'h300;
        c.b_addr = 32'h400;
        c.b_sel = 8'h19;
        c.ctl = 4'h1;
        cfg(c);
        core_u.cyc(1'b1, 1'b1, 1'b0, 2'h1, 1'b0, 32'h300, 32'h0);
        core_u.run(32'h300);
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 32'h400, 32'h0);
        brk("seq_fetch", 1'b1);
        // pair fetch keeps its match across a condition change
        c = '0;
        c.a_addr = 32'h502;
        c.a_sel = 8'h15;
        cfg(c);
        core_u.cyc(1'b1, 1'b1, 1'b0, 2'h2, 1'b1, 32'h500, 32'h0);
        wr(`UBM_OFS_A_ADDR, 32'h600);
        core_u.run(32'h502);
        brk("pair_keep", 1'b1);
        // mask level gate, then hold until accepted
        c.a_addr = 32'h100;
        c.a_sel = 8'h19;
        cfg(c);
        @(posedge pclk);
        interrupt_mask_level <= 4'hf;
        core_u.cyc(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 32'h100, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK("break_req", 1'b0, break_req)
        interrupt_mask_level <= 4'he;
        @(posedge pclk);
        `CHK("break_req", 1'b1, break_req)
        repeat (4) @(posedge pclk);
        `CHK("break_req", 1'b1, break_req)
        core_u.ack();
        @(posedge pclk);
        `CHK("break_req", 1'b0, break_req)
        stop_test();
    end
endmodule

// ---- dv/ubm_core_model.sv ----
// stand-in for the processor core and bus masters seen by the matcher
`timescale 1ns/100ps
module ubm_core_model (
    input wire logic pclk,
    output ubm_pkg::ubm_cycle_t bus_cycle,
    output ubm_pkg::ubm_exec_t exec_info,
    output logic break_ack
);
    import ubm_pkg::*;
    ////////////////////////////////////////////////////////////
    // idle values from time zero
    initial begin
        bus_cycle = '0;
        exec_info = '0;
        break_ack = 1'b0;
    end
    // one observed cycle, then the lines drift to inverted junk
    task cyc(input logic cpu, input logic f, input logic w,
             input logic [1:0] sz, input logic pr, input logic [31:0] a,
             input logic [31:0] d);
        ubm_cycle_t k;
        k = '{1'b1, cpu, 1'b0, f & cpu, w & ~f, sz, pr & f, a, d};
        if (k.fetch) k.addr[0] = 1'b0;
        @(posedge pclk);
        bus_cycle <= k;
        @(posedge pclk);
        bus_cycle <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, ~a, ~d};
    endtask
    // instruction about to execute, then its completion a cycle later
    task run(input logic [31:0] a);
        @(posedge pclk);
        exec_info <= '{1'b1, 1'b0, a};
        @(posedge pclk);
        exec_info <= '{1'b0, 1'b1, a};
        @(posedge pclk);
        exec_info <= '{1'b0, 1'b0, ~a};
    endtask
    // one cpu data read seen on the external bus
    task xcyc(input logic [31:0] a);
        @(posedge pclk);
        bus_cycle <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, a, 32'h0};
        @(posedge pclk);
        bus_cycle <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, ~a, 32'h0};
    endtask
    // exception accepted, one cycle pulse
    task ack();
        @(posedge pclk);
        break_ack <= 1'b1;
        @(posedge pclk);
        break_ack <= 1'b0;
    endtask
endmodule

// ---- verilog/ubm_defs.svh ----
// offsets, field positions, reset values and timing for the break matcher
`ifndef UBM_DEFS_SVH
`define UBM_DEFS_SVH
`define UBM_OFS_A_ADDR 8'h00
`define UBM_OFS_A_MASK 8'h04
`define UBM_OFS_A_SEL 8'h08
`define UBM_OFS_B_ADDR 8'h0c
`define UBM_OFS_B_MASK 8'h10
`define UBM_OFS_B_SEL 8'h14
`define UBM_OFS_B_DATA 8'h18
`define UBM_OFS_B_DMASK 8'h1c
`define UBM_OFS_CTRL 8'h20
`define UBM_OFS_IRQ_STS 8'h24
`define UBM_OFS_IRQ_MSK 8'h28
// bus cycle select fields
`define UBM_SEL_CPU 0
`define UBM_SEL_DMA 1
`define UBM_SEL_FETCH 2
`define UBM_SEL_DATA 3
`define UBM_SEL_RD 4
`define UBM_SEL_WR 5
`define UBM_SEL_SZ_LO 6
// control fields
`define UBM_CTL_SEQ 0
`define UBM_CTL_A_AFTER 1
`define UBM_CTL_B_AFTER 2
`define UBM_CTL_COMPAT 3
`define UBM_CTL_FLAG_A 4
`define UBM_CTL_FLAG_B 5
// irq status bits
`define UBM_IRQ_HIT_A 0
`define UBM_IRQ_HIT_B 1
`define UBM_IRQ_BREAK 2
// reset values
`define UBM_RST_WORD 32'h0000_0000
`define UBM_RST_SEL 8'h00
`define UBM_RST_CTL 4'h0
// settle delay of a register write, in cycles
`define UBM_APPLY_CYC 2'h3
// highest processor mask level that still admits a break
`define UBM_IMASK_MAX 4'he
`endif

// ---- verilog/ubm_pkg.sv ----
// types shared by the break matcher
package ubm_pkg;
    // one observed bus cycle
    typedef struct packed {
        logic valid;
        logic from_cpu;
        logic ext;
        logic fetch;
        logic write;
        logic [1:0] size;
        logic pair;
        logic [31:0] addr;
        logic [31:0] data;
    } ubm_cycle_t;
    // instruction execution report
    typedef struct packed {
        logic start;
        logic done;
        logic [31:0] addr;
    } ubm_exec_t;
    // software visible break setup
    typedef struct packed {
        logic [31:0] a_addr;
        logic [31:0] a_mask;
        logic [7:0] a_sel;
        logic [31:0] b_addr;
        logic [31:0] b_mask;
        logic [7:0] b_sel;
        logic [31:0] b_data;
        logic [31:0] b_dmask;
        logic [3:0] ctl;
    } ubm_cfg_t;
    typedef enum logic [1:0] {UBM_SZ_BYTE, UBM_SZ_WORD, UBM_SZ_LONG}
        ubm_size_t;
endpackage

// ---- verilog/ubm_top.sv ----
// two-channel bus cycle break matcher with apb register access
//
// Behaviour
// - registers answer only cpu-originated bus accesses
// - sequential break needs b after a
// - writes apply after three cycles; reads wait
// - paired fetch keeps condition seen at fetch
// - rematch breaks again when mask level below fifteen
// - fetch condition requiring write never matches
// - fetch condition on odd address never matches
// - dma fetch condition never matches
// - set mask bits exclude address/data bits
// - native mode matches covering word/longword accesses
// - compatible mode compares full data address
// - native skips unexecuted fetches; compatible does not
// - compatible mode: no external breaks, fetch before
// - compatible mode leaves match flags alone
`timescale 1ns/100ps
`include "ubm_defs.svh"
module ubm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic req_from_cpu,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ubm_pkg::ubm_cycle_t bus_cycle,
    input wire ubm_pkg::ubm_exec_t exec_info,
    input wire logic [3:0] interrupt_mask_level,
    input wire logic break_ack,
    output logic break_req,
    output logic irq
);
    import ubm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    ubm_cfg_t cfg_r, cfg_nxt; // written setup
    ubm_cfg_t act_r, act_nxt; // setup the matcher uses
    logic [1:0] cnt_r, cnt_nxt; // settle countdown
    logic [1:0] flag_r, flag_nxt; // per-channel match flags
    logic [2:0] sts_r, sts_nxt; // sticky irq status
    logic [2:0] msk_r, msk_nxt; // irq mask
    logic [31:0] rdata_r, rdata_nxt; // read data
    logic a_seen_r, a_seen_nxt; // channel a matched earlier
    logic pa_r, pa_nxt, pb_r, pb_nxt; // pending fetch matches
    logic [31:0] pa_addr_r, pa_addr_nxt, pb_addr_r, pb_addr_nxt;
    logic pend_r, pend_nxt; // break request latch
    // combinational
    logic acc, wr_acc, rd_acc, cpu_ok, compat;
    logic fa0, fa1, fb0, fb1, fhit_a, fhit_b, dhit_a, dhit_b;
    logic hit_a, hit_b, brk_ev;

    ////////////////////////////////////////////////////////////////////
    // condition compare for one channel on one address
    function automatic logic chan_hit(input ubm_cycle_t c,
            input logic [31:0] a, input logic [31:0] ba,
            input logic [31:0] am, input logic [7:0] sel,
            input logic cmp32);
        logic [31:0] cm;
        logic ok;
        cm = ~am;
        // native data access: covering word/longword still hits
        if (!c.fetch && !cmp32 && c.size == UBM_SZ_LONG) begin
            cm[1:0] = 2'h0;
        end else if (!c.fetch && !cmp32 && c.size == UBM_SZ_WORD) begin
            cm[0] = 1'b0;
        end
        ok = ((a ^ ba) & cm) == 32'h0;
        ok = ok && (c.from_cpu ? sel[`UBM_SEL_CPU] : sel[`UBM_SEL_DMA]);
        ok = ok && (c.fetch ? sel[`UBM_SEL_FETCH] : sel[`UBM_SEL_DATA]);
        ok = ok && (c.write ? sel[`UBM_SEL_WR] : sel[`UBM_SEL_RD]);
        ok = ok && (sel[7:6] == 2'h0 || sel[7:6] == c.size + 2'h1);
        // fetches are cpu reads at even addresses only
        if (c.fetch && (c.write || ba[0] || !c.from_cpu)) begin
            ok = 1'b0;
        end
        if (cmp32 && c.ext) begin
            ok = 1'b0;
        end
        return c.valid && ok;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // apb decode; non-cpu masters get an error and touch nothing
    always_comb begin
        compat = act_r.ctl[`UBM_CTL_COMPAT];
        cpu_ok = req_from_cpu;
        // a read waits until every pending write has settled
        pready = !(psel && !pwrite && cnt_r != 2'h0 && cpu_ok);
        pslverr = psel && penable && !cpu_ok;
        acc = psel && penable && pready && cpu_ok;
        wr_acc = acc && pwrite;
        rd_acc = acc && !pwrite;
        prdata = rdata_r;
    end

    ////////////////////////////////////////////////////////////////////
    // register file next values
    always_comb begin
        cfg_nxt = cfg_r;
        msk_nxt = msk_r;
        cnt_nxt = (cnt_r != 2'h0) ? cnt_r - 2'h1 : 2'h0;
        act_nxt = (cnt_r == 2'h1) ? cfg_r : act_r;
        rdata_nxt = 32'h0;
        if (wr_acc) begin
            cnt_nxt = `UBM_APPLY_CYC;
            case (paddr)
                `UBM_OFS_A_ADDR: cfg_nxt.a_addr = pwdata;
                `UBM_OFS_A_MASK: cfg_nxt.a_mask = pwdata;
                `UBM_OFS_A_SEL: cfg_nxt.a_sel = pwdata[7:0];
                `UBM_OFS_B_ADDR: cfg_nxt.b_addr = pwdata;
                `UBM_OFS_B_MASK: cfg_nxt.b_mask = pwdata;
                `UBM_OFS_B_SEL: cfg_nxt.b_sel = pwdata[7:0];
                `UBM_OFS_B_DATA: cfg_nxt.b_data = pwdata;
                `UBM_OFS_B_DMASK: cfg_nxt.b_dmask = pwdata;
                `UBM_OFS_CTRL: cfg_nxt.ctl = pwdata[3:0];
                `UBM_OFS_IRQ_MSK: msk_nxt = pwdata[2:0];
                // unmapped writes are dropped and keep the countdown going
                default: cnt_nxt = (cnt_r != 2'h0) ? cnt_r - 2'h1 : 2'h0;
            endcase
        end
        // read data latched in the setup cycle, stable through access
        if (psel && !penable && !pwrite && cpu_ok) begin
            case (paddr)
                `UBM_OFS_A_ADDR: rdata_nxt = cfg_r.a_addr;
                `UBM_OFS_A_MASK: rdata_nxt = cfg_r.a_mask;
                `UBM_OFS_A_SEL: rdata_nxt = {24'h0, cfg_r.a_sel};
                `UBM_OFS_B_ADDR: rdata_nxt = cfg_r.b_addr;
                `UBM_OFS_B_MASK: rdata_nxt = cfg_r.b_mask;
                `UBM_OFS_B_SEL: rdata_nxt = {24'h0, cfg_r.b_sel};
                `UBM_OFS_B_DATA: rdata_nxt = cfg_r.b_data;
                `UBM_OFS_B_DMASK: rdata_nxt = cfg_r.b_dmask;
                `UBM_OFS_CTRL: rdata_nxt = {26'h0, flag_r, cfg_r.ctl};
                `UBM_OFS_IRQ_STS: rdata_nxt = {29'h0, sts_r};
                `UBM_OFS_IRQ_MSK: rdata_nxt = {29'h0, msk_r};
                default: rdata_nxt = 32'h0;
            endcase
        end else if (psel && penable) begin
            rdata_nxt = rdata_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // matching; fetch matches are parked until execution in native mode
    always_comb begin
        fa0 = chan_hit(bus_cycle, bus_cycle.addr, act_r.a_addr,
            act_r.a_mask, act_r.a_sel, compat);
        fa1 = bus_cycle.pair && chan_hit(bus_cycle, bus_cycle.addr +
            32'h2, act_r.a_addr, act_r.a_mask, act_r.a_sel, compat);
        fb0 = chan_hit(bus_cycle, bus_cycle.addr, act_r.b_addr,
            act_r.b_mask, act_r.b_sel, compat);
        fb1 = bus_cycle.pair && chan_hit(bus_cycle, bus_cycle.addr +
            32'h2, act_r.b_addr, act_r.b_mask, act_r.b_sel, compat);
        // data cycles: channel b also checks masked data
        dhit_a = !bus_cycle.fetch && fa0;
        dhit_b = !bus_cycle.fetch && fb0 && ((bus_cycle.data ^
            act_r.b_data) & ~act_r.b_dmask) == 32'h0;
        // the second half of a pair is judged now; in native mode it fires later
        pa_nxt = pa_r;
        pa_addr_nxt = pa_addr_r;
        pb_nxt = pb_r;
        pb_addr_nxt = pb_addr_r;
        fhit_a = 1'b0;
        fhit_b = 1'b0;
        if (compat) begin
            // compatible: fires at the fetch itself, even if unexecuted
            fhit_a = bus_cycle.fetch && (fa0 || fa1);
            fhit_b = bus_cycle.fetch && (fb0 || fb1);
            pa_nxt = 1'b0;
            pb_nxt = 1'b0;
        end else begin
            // native: only an instruction that really executes breaks
            if (pa_r && exec_info.addr == pa_addr_r &&
                    (act_r.ctl[`UBM_CTL_A_AFTER] ? exec_info.done
                    : exec_info.start)) begin
                fhit_a = 1'b1;
                pa_nxt = 1'b0;
            end
            if (pb_r && exec_info.addr == pb_addr_r &&
                    (act_r.ctl[`UBM_CTL_B_AFTER] ? exec_info.done
                    : exec_info.start)) begin
                fhit_b = 1'b1;
                pb_nxt = 1'b0;
            end
            if (bus_cycle.fetch && (fa0 || fa1)) begin
                pa_nxt = 1'b1;
                pa_addr_nxt = fa0 ? bus_cycle.addr
                    : bus_cycle.addr + 32'h2;
            end
            if (bus_cycle.fetch && (fb0 || fb1)) begin
                pb_nxt = 1'b1;
                pb_addr_nxt = fb0 ? bus_cycle.addr
                    : bus_cycle.addr + 32'h2;
            end
        end
        hit_a = dhit_a || fhit_a;
        hit_b = dhit_b || fhit_b;
    end

    ////////////////////////////////////////////////////////////////////
    // break decision, flags, request latch and irq status
    always_comb begin
        // registered a_seen means a matched in an earlier cycle
        if (act_r.ctl[`UBM_CTL_SEQ]) begin
            brk_ev = hit_b && a_seen_r;
            a_seen_nxt = (a_seen_r || hit_a) && !brk_ev;
        end else begin
            brk_ev = hit_a || hit_b;
            a_seen_nxt = 1'b0;
        end
        // flags: writing zero clears, a hit in that cycle wins
        flag_nxt = flag_r;
        if (wr_acc && paddr == `UBM_OFS_CTRL) begin
            flag_nxt = flag_r & pwdata[5:4];
        end
        if (!compat) begin
            flag_nxt = flag_nxt | {hit_b, hit_a};
        end
        // held until the processor takes the exception
        pend_nxt = brk_ev || (pend_r && !break_ack);
        // a read clears only the bits it returned, so an event that
        // lands between setup and access is not lost; new events win
        sts_nxt = sts_r;
        if (rd_acc && paddr == `UBM_OFS_IRQ_STS) begin
            sts_nxt = sts_r & ~rdata_r[2:0];
        end
        sts_nxt = sts_nxt | {brk_ev, hit_b, hit_a};
        // the break outranks mask levels up to fourteen
        break_req = pend_r &&
            interrupt_mask_level <= `UBM_IMASK_MAX;
        irq = |(sts_r & msk_r);
    end

    ////////////////////////////////////////////////////////////////////
    // all registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= '{`UBM_RST_WORD, `UBM_RST_WORD, `UBM_RST_SEL,
                `UBM_RST_WORD, `UBM_RST_WORD, `UBM_RST_SEL,
                `UBM_RST_WORD, `UBM_RST_WORD, `UBM_RST_CTL};
            act_r <= '{`UBM_RST_WORD, `UBM_RST_WORD, `UBM_RST_SEL,
                `UBM_RST_WORD, `UBM_RST_WORD, `UBM_RST_SEL,
                `UBM_RST_WORD, `UBM_RST_WORD, `UBM_RST_CTL};
            cnt_r <= 2'h0;
            flag_r <= 2'h0;
            sts_r <= 3'h0;
            msk_r <= 3'h0;
            rdata_r <= 32'h0;
            a_seen_r <= 1'b0;
            pa_r <= 1'b0;
            pb_r <= 1'b0;
            pa_addr_r <= 32'h0;
            pb_addr_r <= 32'h0;
            pend_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            act_r <= act_nxt;
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
            sts_r <= sts_nxt;
            msk_r <= msk_nxt;
            rdata_r <= rdata_nxt;
            a_seen_r <= a_seen_nxt;
            pa_r <= pa_nxt;
            pb_r <= pb_nxt;
            pa_addr_r <= pa_addr_nxt;
            pb_addr_r <= pb_addr_nxt;
            pend_r <= pend_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a mapped write that restarts the settle countdown
    sequence s_write_done;
        wr_acc && cnt_nxt == `UBM_APPLY_CYC;
    endsequence
    sequence s_quiet3;
        (!wr_acc) [*3];
    endsequence
    chk_foreign_write: assert property (
        psel && penable && !req_from_cpu |=> cfg_r == $past(cfg_r))
        else $error("non-cpu access changed setup");
    chk_seq_same: assert property (
        act_r.ctl[`UBM_CTL_SEQ] && !a_seen_r |-> !brk_ev)
        else $error("sequential break without earlier a match");
    chk_apply_three: assert property (
        s_write_done ##1 s_quiet3 |=> act_r == cfg_r)
        else $error("write not applied after three cycles");
    chk_apply_early: assert property (
        s_write_done |=> ##1 (act_r == $past(act_r)) [*2])
        else $error("write applied too early");
    chk_read_waits: assert property (
        rd_acc |-> cnt_r == 2'h0)
        else $error("read finished before settings applied");
    chk_mask_level: assert property (
        pend_r && interrupt_mask_level <= `UBM_IMASK_MAX |-> break_req)
        else $error("break held off at low mask level");
    chk_fetch_never: assert property (
        bus_cycle.fetch && (act_r.a_addr[0] || bus_cycle.write ||
        !bus_cycle.from_cpu) |-> !fa0)
        else $error("impossible fetch condition matched");
    chk_compat_flags: assert property (
        compat && !(wr_acc && paddr == `UBM_OFS_CTRL)
        |=> flag_r == $past(flag_r))
        else $error("flag set in compatible mode");
    chk_break_hold: assert property (
        brk_ev ##1 !break_ack |=> pend_r)
        else $error("break request dropped before accept");
    chk_irq_sticky: assert property (
        $rose(sts_r[`UBM_IRQ_BREAK]) && msk_r[`UBM_IRQ_BREAK] |-> irq)
        else $error("unmasked break status not on irq");
endmodule
